/* File: gpt_defines.vh */
`ifndef GPT_DEFINES_VH
`define GPT_DEFINES_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GPT_ADDR_W          12
`define GPT_OFF_SA_CTRL     12'h000
`define GPT_OFF_SA_PERIOD   12'h004
`define GPT_OFF_SA_COUNT    12'h008
`define GPT_OFF_LO_CTRL     12'h00C
`define GPT_OFF_LO_PERIOD   12'h010
`define GPT_OFF_LO_COUNT    12'h014
`define GPT_OFF_UP_CTRL     12'h018
`define GPT_OFF_UP_PERIOD   12'h01C
`define GPT_OFF_UP_COUNT    12'h020
`define GPT_OFF_UP_HOLD     12'h024
`define GPT_OFF_FLAGS       12'h028

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define GPT_BIT_ON          15
`define GPT_BIT_IDLE        13
`define GPT_BIT_GATE        6
`define GPT_BIT_PS_HI       5
`define GPT_BIT_PS_LO       4
`define GPT_BIT_CASCADE     3
`define GPT_BIT_SYNC        2
`define GPT_BIT_CS          1

// ----------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------
`define GPT_MASK_SA_CTRL    16'hA076
`define GPT_MASK_LO_CTRL    16'hA07A
`define GPT_MASK_UP_CTRL    16'hA072
`define GPT_RST_CTRL        16'h0000
`define GPT_RST_PERIOD      16'hFFFF
`define GPT_RST_COUNT       16'h0000

// ----------------------------------------------------------------
// prescale terminal counts (ratio minus one)
// ----------------------------------------------------------------
`define GPT_PS_LIM_1        8'h00
`define GPT_PS_LIM_8        8'h07
`define GPT_PS_LIM_64       8'h3F
`define GPT_PS_LIM_256      8'hFF

`endif

/* File: gpt_top.v */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "gpt_defines.vh"

module gpt_top #(
    parameter ADDR_W = `GPT_ADDR_W
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg  [31:0]       prdata,
    output wire              pready,
    output wire              pslverr,
    input  wire              idle_mode,
    input  wire              standalone_ext_clock_pin,
    input  wire              pair_ext_clock_pin,
    input  wire              upper_ext_clock_pin,
    input  wire              standalone_gate_in,
    input  wire              lower_gate_in,
    input  wire              upper_gate_in,
    output wire              standalone_irq_flag,
    output wire              lower_irq_flag,
    output wire              upper_timer_irq_flag,
    output reg               adc_event_trigger
);

// ----------------------------------------------------------------
// register storage
// ----------------------------------------------------------------
reg  [15:0] ctrl_reg [0:2];
reg  [15:0] period   [0:2];
reg  [15:0] cnt      [0:2];
reg  [15:0] upper_word_hold;
reg  [2:0]  flag;
reg  [31:0] next_prdata;
reg         unmapped;

wire        wr_acc   = psel & penable & pwrite;
wire        rd_setup = psel & ~penable & ~pwrite;
wire        cascade  = ctrl_reg[1][`GPT_BIT_CASCADE];
wire        aligned  = (paddr[1:0] == 2'b00);

wire [2:0]  ext_pin  = {upper_ext_clock_pin, pair_ext_clock_pin, standalone_ext_clock_pin};
wire [2:0]  gate_in  = {upper_gate_in, lower_gate_in, standalone_gate_in};
wire [2:0]  ctrl_wr;
wire [2:0]  tick;
wire [2:0]  gate_ev;

assign ctrl_wr[0] = wr_acc & (paddr == `GPT_OFF_SA_CTRL);
assign ctrl_wr[1] = wr_acc & (paddr == `GPT_OFF_LO_CTRL);
// upper prescaler follows lower control when joined
assign ctrl_wr[2] = wr_acc & (cascade ? (paddr == `GPT_OFF_LO_CTRL) : (paddr == `GPT_OFF_UP_CTRL));

// ----------------------------------------------------------------
// per-timer clocking, gating and prescale
// ----------------------------------------------------------------
genvar i;
generate
    for (i = 0; i < 3; i = i + 1) begin : g_tmr
        wire [15:0] c = (i == 2 && cascade) ? ctrl_reg[1] : ctrl_reg[i];
        reg         sync_a;
        reg         sync_b;
        reg         sync_c;
        reg         raw_d;
        reg         gate_d;
        reg  [7:0]  pre;
        reg  [7:0]  lim;
        wire        run;
        wire        gated;
        wire        ext_edge;
        wire        src;

        // sync bit only exists on the standalone timer; pair always synchronised
        assign ext_edge = (i == 0 && !c[`GPT_BIT_SYNC]) ? (ext_pin[i] & ~raw_d)
                                                         : (sync_b & ~sync_c);
        assign run   = c[`GPT_BIT_ON] & ~(c[`GPT_BIT_IDLE] & idle_mode);
        assign gated = ~c[`GPT_BIT_CS] & c[`GPT_BIT_GATE];
        assign src   = c[`GPT_BIT_CS] ? ext_edge : (gated ? gate_in[i] : 1'b1);

        always @* begin
            case (c[`GPT_BIT_PS_HI:`GPT_BIT_PS_LO])
                2'b00:   lim = `GPT_PS_LIM_1;
                2'b01:   lim = `GPT_PS_LIM_8;
                2'b10:   lim = `GPT_PS_LIM_64;
                2'b11:   lim = `GPT_PS_LIM_256;
                default: lim = `GPT_PS_LIM_1;
            endcase
        end

        assign tick[i]    = run & src & (pre == lim);
        assign gate_ev[i] = run & gated & gate_d & ~gate_in[i];

        always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync_a <= 1'b0;
                sync_b <= 1'b0;
                sync_c <= 1'b0;
                raw_d  <= 1'b0;
                gate_d <= 1'b0;
                pre    <= 8'h00;
            end else begin
                sync_a <= ext_pin[i];
                sync_b <= sync_a;
                sync_c <= sync_b;
                raw_d  <= ext_pin[i];
                gate_d <= gate_in[i];
                // control rewrite while running restarts the prescale phase
                if (!run || ctrl_wr[i]) begin
                    pre <= 8'h00;
                end else if (src) begin
                    pre <= (pre == lim) ? 8'h00 : pre + 8'h01;
                end
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// match detection
// ----------------------------------------------------------------
wire        match0  = (cnt[0] == period[0]);
wire        match1  = (cnt[1] == period[1]);
wire        match2  = (cnt[2] == period[2]);
wire        match32 = ({cnt[2], cnt[1]} == {period[2], period[1]});
wire [31:0] cnt32   = {cnt[2], cnt[1]};
wire [31:0] inc32   = cnt32 + 32'h0000_0001;

wire        set_sa  = (tick[0] & match0) | gate_ev[0];
wire        set_lo  = ~cascade & ((tick[1] & match1) | gate_ev[1]);
wire        set_up  = cascade ? ((tick[1] & match32) | gate_ev[1])
                              : ((tick[2] & match2) | gate_ev[2]);
wire [2:0]  flag_clr = (wr_acc && paddr == `GPT_OFF_FLAGS) ? pwdata[2:0] : 3'b000;

assign standalone_irq_flag  = flag[0];
assign lower_irq_flag       = flag[1];
assign upper_timer_irq_flag = flag[2];

// ----------------------------------------------------------------
// control, period, count and hold strobes
// ----------------------------------------------------------------
wire        wr_up_ctrl   = wr_acc & (paddr == `GPT_OFF_UP_CTRL);
wire        wr_sa_period = wr_acc & (paddr == `GPT_OFF_SA_PERIOD);
wire        wr_lo_period = wr_acc & (paddr == `GPT_OFF_LO_PERIOD);
wire        wr_up_period = wr_acc & (paddr == `GPT_OFF_UP_PERIOD);
wire        wr_sa_count  = wr_acc & (paddr == `GPT_OFF_SA_COUNT);
wire        wr_lo_count  = wr_acc & (paddr == `GPT_OFF_LO_COUNT);
wire        wr_up_count  = wr_acc & (paddr == `GPT_OFF_UP_COUNT);
wire        wr_hold      = wr_acc & (paddr == `GPT_OFF_UP_HOLD);
wire        rd_lo_count  = rd_setup & (paddr == `GPT_OFF_LO_COUNT);

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ctrl_reg[0] <= `GPT_RST_CTRL;
        ctrl_reg[1] <= `GPT_RST_CTRL;
        ctrl_reg[2] <= `GPT_RST_CTRL;
    end else begin
        if (ctrl_wr[0]) begin
            ctrl_reg[0] <= pwdata[15:0] & `GPT_MASK_SA_CTRL;
        end
        if (ctrl_wr[1]) begin
            ctrl_reg[1] <= pwdata[15:0] & `GPT_MASK_LO_CTRL;
        end
        // stored even while joined, but then unused
        if (wr_up_ctrl) begin
            ctrl_reg[2] <= pwdata[15:0] & `GPT_MASK_UP_CTRL;
        end
    end
end

// ----------------------------------------------------------------
// period registers
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        period[0] <= `GPT_RST_PERIOD;
        period[1] <= `GPT_RST_PERIOD;
        period[2] <= `GPT_RST_PERIOD;
    end else begin
        if (wr_sa_period) begin
            period[0] <= pwdata[15:0];
        end
        if (wr_lo_period) begin
            period[1] <= pwdata[15:0];
        end
        if (wr_up_period) begin
            period[2] <= pwdata[15:0];
        end
    end
end

// ----------------------------------------------------------------
// upper word hold
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        upper_word_hold <= `GPT_RST_COUNT;
    end else if (rd_lo_count && cascade) begin
        // captured in setup so the read data and the hold agree
        upper_word_hold <= cnt[2];
    end else if (wr_hold) begin
        upper_word_hold <= pwdata[15:0];
    end
end

// ----------------------------------------------------------------
// count registers; a software write beats a tick
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cnt[0] <= `GPT_RST_COUNT;
        cnt[1] <= `GPT_RST_COUNT;
        cnt[2] <= `GPT_RST_COUNT;
    end else begin
        if (wr_sa_count) begin
            cnt[0] <= pwdata[15:0];
        end else if (tick[0]) begin
            cnt[0] <= match0 ? 16'h0000 : cnt[0] + 16'h0001;
        end
        if (cascade) begin
            if (wr_lo_count) begin
                cnt[1] <= pwdata[15:0];
                cnt[2] <= upper_word_hold;
            end else if (wr_up_count) begin
                cnt[2] <= pwdata[15:0];
            end else if (tick[1]) begin
                cnt[1] <= match32 ? 16'h0000 : inc32[15:0];
                cnt[2] <= match32 ? 16'h0000 : inc32[31:16];
            end
        end else begin
            if (wr_lo_count) begin
                cnt[1] <= pwdata[15:0];
            end else if (tick[1]) begin
                cnt[1] <= match1 ? 16'h0000 : cnt[1] + 16'h0001;
            end
            if (wr_up_count) begin
                cnt[2] <= pwdata[15:0];
            end else if (tick[2]) begin
                cnt[2] <= match2 ? 16'h0000 : cnt[2] + 16'h0001;
            end
        end
    end
end

// ----------------------------------------------------------------
// flags and adc trigger
// ----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        flag              <= 3'h0;
        adc_event_trigger <= 1'h0;
    end else begin
        // set beats clear when both land together
        flag              <= (flag & ~flag_clr) | {set_up, set_lo, set_sa};
        adc_event_trigger <= cascade ? (tick[1] & match32) : (tick[2] & match2);
    end
end

// ----------------------------------------------------------------
// apb read path
// ----------------------------------------------------------------
always @* begin
    next_prdata = 32'h0000_0000;
    unmapped    = 1'b0;
    if (!aligned) begin
        unmapped = 1'b1;
    end else begin
        case (paddr)
            `GPT_OFF_SA_CTRL:   next_prdata[15:0] = ctrl_reg[0];
            `GPT_OFF_SA_PERIOD: next_prdata[15:0] = period[0];
            `GPT_OFF_SA_COUNT:  next_prdata[15:0] = cnt[0];
            `GPT_OFF_LO_CTRL:   next_prdata[15:0] = ctrl_reg[1];
            `GPT_OFF_LO_PERIOD: next_prdata[15:0] = period[1];
            `GPT_OFF_LO_COUNT:  next_prdata[15:0] = cnt[1];
            `GPT_OFF_UP_CTRL:   next_prdata[15:0] = ctrl_reg[2];
            `GPT_OFF_UP_PERIOD: next_prdata[15:0] = period[2];
            `GPT_OFF_UP_COUNT:  next_prdata[15:0] = cnt[2];
            `GPT_OFF_UP_HOLD:   next_prdata[15:0] = upper_word_hold;
            `GPT_OFF_FLAGS:     next_prdata[2:0]  = flag;
            default:            unmapped = 1'b1;
        endcase
    end
end

// zero wait states: data is ready by the access phase
assign pready  = 1'b1;
assign pslverr = psel & penable & unmapped;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
        prdata <= next_prdata;
    end
end

endmodule // gpt_top

/* File: gpt_top_props.sv */
`timescale 1ns/100ps
// ----
// port checker
// ----
module gpt_props #(
    parameter ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              standalone_irq_flag,
    input wire logic              lower_irq_flag,
    input wire logic              upper_timer_irq_flag,
    input wire logic              adc_event_trigger
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel & penable;
    wire clr = acc & pwrite & (paddr == 12'h028);
    wire c0  = clr & pwdata[0];
    wire c1  = clr & pwdata[1];
    wire c2  = clr & pwdata[2];
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_idle; !acc |-> !pslverr; endproperty
    a_err_idle: assert property (p_err_idle) else $error("error outside access");
    property p_err_unal; acc && paddr[1:0] != 2'h0 |-> pslverr; endproperty
    a_err_unal: assert property (p_err_unal) else $error("unaligned not refused");
    property p_err_map; acc && paddr[1:0] == 2'h0 && paddr <= 12'h028 |-> !pslverr; endproperty
    a_err_map: assert property (p_err_map) else $error("mapped access refused");
    property p_hi_zero; prdata[31:16] == 16'h0000; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read data upper half set");
    property p_sa_clr; $fell(standalone_irq_flag) |-> $past(c0); endproperty
    a_sa_clr: assert property (p_sa_clr) else $error("standalone flag lost");
    property p_lo_clr; $fell(lower_irq_flag) |-> $past(c1); endproperty
    a_lo_clr: assert property (p_lo_clr) else $error("lower flag lost");
    property p_up_clr; $fell(upper_timer_irq_flag) |-> $past(c2); endproperty
    a_up_clr: assert property (p_up_clr) else $error("upper flag lost");
    property p_adc; adc_event_trigger |-> upper_timer_irq_flag; endproperty
    a_adc: assert property (p_adc) else $error("trigger without match");
endmodule // gpt_props

bind gpt_top gpt_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .standalone_irq_flag(standalone_irq_flag),
    .lower_irq_flag(lower_irq_flag), .upper_timer_irq_flag(upper_timer_irq_flag),
    .adc_event_trigger(adc_event_trigger));

/* File: gpt_top_tb_top.sv */
`timescale 1ns/100ps
// ----
// gpt bench
// ----
module gpt_top_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, idle_mode = 0, ck = 0, g = 0, err;
    logic [11:0] paddr = 0, c;
    logic [31:0] pwdata = 0, rd, r0;
    wire  [31:0] prdata;
    wire         pready, pslverr, sa_f, lo_f, up_f, adc;
    int          num_errors = 0, checked = 0, adc_n = 0, n, k, i, j, t;
    int          dv [4] = '{1, 8, 64, 256};
    logic [15:0] msk [3] = '{16'hA076, 16'hA07A, 16'hA072};

    gpt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idle_mode(idle_mode), .standalone_ext_clock_pin(ck), .pair_ext_clock_pin(ck),
        .upper_ext_clock_pin(ck), .standalone_gate_in(g), .lower_gate_in(g), .upper_gate_in(g),
        .standalone_irq_flag(sa_f), .lower_irq_flag(lo_f), .upper_timer_irq_flag(up_f),
        .adc_event_trigger(adc));

    initial forever #2.5 pclk = ~pclk;
    always @(posedge pclk) if (adc === 1'b1) adc_n++;

    task automatic results();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // tol widens the match for counts that depend on prescaler phase
    task automatic chk(input logic [31:0] gv, input logic [31:0] ev, input int tol = 0);
        checked++;
        if (tol == 0 ? gv !== ev : ($isunknown(gv) || gv + tol < ev || gv > ev + tol)) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, gv, ev);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 40);
        if (t >= 40) begin
            num_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic run(input logic [11:0] a, input logic [31:0] ctl, input int m);
        apb(1, a, ctl | 32'h8000);
        repeat (m) @(posedge pclk);
        apb(1, a, ctl);
        apb(0, a + 12'h8, 0);
    endtask

    initial begin
        t = $urandom(24);
        repeat (3) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 3; i++) begin
            c = 12'(i * 12);
            apb(0, c, 0);
            chk(rd, 0);
            apb(0, c + 12'h4, 0);
            chk(rd, 32'hFFFF);
            apb(1, c, 32'hFFFF);
            apb(0, c, 0);
            chk(rd, {16'h0, msk[i]});
            apb(1, c, 0);
        end
        apb(1, 12'h02C, 32'hFFFF);
        chk(err, 1);
        apb(0, 12'h002, 0);
        chk(err, 1);
        chk(rd, 0);
        $display("registers done");
        for (i = 0; i < 3; i++) for (j = 0; j < 4; j++) begin
            c = 12'(i * 12);
            n = dv[j] * (2 + $urandom % 4);
            apb(1, c + 12'h8, 0);
            run(c, 32'(j << 4), n);
            chk(rd, (n + 3) / dv[j], 1);
            r0 = rd;
            repeat (20) @(posedge pclk);
            apb(0, c + 12'h8, 0);
            chk(rd, r0);
        end
        apb(1, 12'h8, 0);
        apb(1, 0, 32'h8010);
        repeat (6) apb(1, 0, 32'h8010);
        apb(1, 0, 0);
        apb(0, 12'h8, 0);
        chk(rd, 0);
        $display("prescale done");
        for (k = 0; k < 4; k++) begin
            idle_mode <= k < 2;
            g <= k == 3;
            apb(1, 12'h8, 0);
            run(0, k == 0 ? 32'h2000 : k > 1 ? 32'h40 : 0, 30);
            chk(rd, k[0] ? 33 : 0, k[0]);
        end
        idle_mode <= 0;
        apb(1, 12'h028, 7);
        apb(1, 0, 32'h8040);
        repeat (5) @(posedge pclk);
        g <= 0;
        repeat (4) @(posedge pclk);
        chk(sa_f, 1);
        apb(1, 0, 0);
        $display("idle gate done");
        for (k = 0; k < 4; k++) begin
            c = k < 2 ? 12'h0 : 12'(k * 12 - 12);
            j = 3 + $urandom % 8;
            apb(1, c + 12'h8, 0);
            apb(1, c, k == 0 ? 32'h8046 : 32'h8042);
            repeat (j) begin
                ck <= 1;
                repeat (3) @(posedge pclk);
                ck <= 0;
                repeat (3) @(posedge pclk);
            end
            repeat (6) @(posedge pclk);
            apb(1, c, 0);
            apb(0, c + 12'h8, 0);
            chk(rd, j);
        end
        $display("external done");
        apb(1, 12'h028, 7);
        k = 2 + $urandom % 5;
        apb(1, 12'h4, k);
        apb(1, 12'h8, 0);
        apb(1, 0, 32'h8000);
        repeat (k) @(posedge pclk);
        chk(sa_f, 0);
        repeat (3) @(posedge pclk);
        chk(sa_f, 1);
        apb(1, 0, 0);
        apb(0, 12'h8, 0);
        chk(rd <= k, 1);
        apb(0, 12'h028, 0);
        chk(rd, 1);
        $display("match done");
        apb(1, 12'h028, 7);
        apb(1, 12'h00C, 32'h0008);
        apb(1, 12'h018, 32'h8030);
        apb(1, 12'h024, 0);
        apb(1, 12'h014, 32'hFFFC);
        apb(1, 12'h010, 32'hFFFF);
        apb(1, 12'h01C, 1);
        run(12'h00C, 32'h0008, 12);
        chk(rd, 11, 1);
        apb(0, 12'h024, 0);
        chk(rd, 1);
        chk(up_f, 0);
        apb(1, 12'h024, 0);
        apb(1, 12'h014, 32'hFFFC);
        apb(1, 12'h010, 2);
        adc_n = 0;
        apb(1, 12'h00C, 32'h8008);
        t = 0;
        while (up_f !== 1'b1 && t < 40) begin
            @(posedge pclk);
            t++;
        end
        chk(up_f, 1);
        chk(lo_f, 0);
        repeat (2) @(posedge pclk);
        chk(adc_n > 0, 1);
        apb(1, 12'h00C, 0);
        $display("cascade done");
        results();
    end
endmodule // gpt_top_tb_top
